// [rtl/asf_status_flags.sv]
/*
  Status flag bank of a multi-channel converter: threshold flags per result
  register, gain calibration overflow, unread data and completion flags, the
  interrupt enable mask and the active-low interrupt output.
  Assumes a register port already decoded by the serial interface: one-cycle
  read and write strobes with a 7-bit address, all on clk.

// Summary of operation
// - Status read clears the clear-on-read flags.
// - Over-range set on high value or overflow.
// - Over-range flags hold until status read.
// - Under-range set on low value or underflow.
// - Under-range flags hold until status read.
// - Gain calibration overflow sets its flag.
// - Gain flag clears on read or good calibration.
// - Eight unread bits; flag is their OR.
// - Unread flag drops after all pending reads.
// - Status read leaves unread bits untouched.
// - Wait done; cleared by read or wait start.
// - Calibration done; cleared by read or start.
// - Sequence flag after one full iteration.
// - Sequence clear: read, start write, wraparound.
// - Conversion flag on new result stored.
// - Conversion clear: read, start, pre-result.
// - Channel n at bits 16+n and 8+n.
// - Interrupt asserts on any enabled set flag.
// - Enable mask resets to conversion only.
*/
`timescale 1ns/1ps
`default_nettype none
module asf_status_flags (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [23:0] reg_wdata_i,
  output logic [23:0] reg_rdata_o,
  input wire logic result_wr_i,
  input wire logic [2:0] result_sel_i,
  input wire logic [23:0] result_value_i,
  input wire logic digital_over_i,
  input wire logic digital_under_i,
  input wire logic [23:0] upper_limit_setting,
  input wire logic [23:0] lower_limit_setting,
  input wire logic gain_cal_done_i,
  input wire logic [23:0] system_gain_coefficient,
  input wire logic gain_cal_saturated_i,
  input wire logic wait_done_i,
  input wire logic wait_launch_wr_i,
  input wire logic cal_done_i,
  input wire logic cal_launch_wr_i,
  input wire logic seq_iteration_done_i,
  input wire logic sequence_launch_wr_i,
  input wire logic seq_wrap_i,
  input wire logic conversion_launch_wr_i,
  input wire logic conv_pre_result_i,
  output logic irq_out_n
);
  import asf_pkg::*;

  logic status_rd;
  logic mask_wr;
  logic [ASF_CHANNELS-1:0] data_rd;
  logic [ASF_CHANNELS-1:0] data_wr;
  logic [23:0] status_now;
  logic [23:0] irq_enable_mask_q;
  logic [23:0] irq_enable_mask_d;
  logic [23:0] rdata_q;
  logic [23:0] rdata_d;
  logic irq_n_q;
  logic irq_n_d;
  logic [ASF_CHANNELS-1:0] above_limit_flag;
  logic [ASF_CHANNELS-1:0] below_limit_flag;
  logic [ASF_CHANNELS-1:0] unread_bits;
  logic unread_any;
  logic gain_cal_overflow_flag;
  logic wait_flag;
  logic cal_flag;
  logic sequence_finished_flag;
  logic conversion_finished_flag;
  logic gain_ovf_event;
  logic gain_valid_event;

  // Register port decode.
  assign status_rd = reg_rd_i && (reg_addr_i == ASF_EVENT_FLAGS_OFFSET);
  assign mask_wr = reg_wr_i && (reg_addr_i == ASF_IRQ_ENABLE_OFFSET);

  // A gain calibration overflows when flagged saturated or pinned at full code.
  assign gain_ovf_event = gain_cal_done_i &&
    (gain_cal_saturated_i || (system_gain_coefficient == ASF_GAIN_MAX_CODE));
  assign gain_valid_event = gain_cal_done_i && !gain_ovf_event;

  // Per-channel threshold flags and data strobes.
  genvar ch;
  generate
    for (ch = 0; ch < ASF_CHANNELS; ch++)
    begin : g_chan
      logic hit;
      logic above_set;
      logic below_set;
      assign hit = result_wr_i && (result_sel_i == 3'(ch));
      assign data_wr[ch] = hit;
      assign data_rd[ch] = reg_rd_i && (reg_addr_i == ASF_DATA_BASE_OFFSET + 7'(ch));
      assign above_set = hit && ((result_value_i > upper_limit_setting) || digital_over_i);
      assign below_set = hit && ((result_value_i < lower_limit_setting) || digital_under_i);
      // Clear only what the read returned, so a late event stays pending.
      asf_sticky u_above (
        .clk(clk),
        .reset_n(reset_n),
        .set_i(above_set),
        .clr_i(status_rd && above_limit_flag[ch]),
        .flag_o(above_limit_flag[ch])
      );
      asf_sticky u_below (
        .clk(clk),
        .reset_n(reset_n),
        .set_i(below_set),
        .clr_i(status_rd && below_limit_flag[ch]),
        .flag_o(below_limit_flag[ch])
      );
    end
  endgenerate

  // Unread tracking ignores status reads entirely.
  asf_unread u_unread (
    .clk(clk),
    .reset_n(reset_n),
    .written_i(data_wr),
    .read_i(data_rd),
    .bits_o(unread_bits),
    .any_o(unread_any)
  );

  // Gain overflow also clears when a later calibration comes out valid.
  asf_sticky u_gain (
    .clk(clk),
    .reset_n(reset_n),
    .set_i(gain_ovf_event),
    .clr_i((status_rd && gain_cal_overflow_flag) || gain_valid_event),
    .flag_o(gain_cal_overflow_flag)
  );

  // Wait completion.
  asf_sticky u_wait (
    .clk(clk),
    .reset_n(reset_n),
    .set_i(wait_done_i),
    .clr_i((status_rd && wait_flag) || wait_launch_wr_i),
    .flag_o(wait_flag)
  );

  // Calibration completion.
  asf_sticky u_cal (
    .clk(clk),
    .reset_n(reset_n),
    .set_i(cal_done_i || gain_cal_done_i),
    .clr_i((status_rd && cal_flag) || cal_launch_wr_i),
    .flag_o(cal_flag)
  );

  // Sequence completion; the launch strobe covers writes made by the sequencer.
  asf_sticky u_seq (
    .clk(clk),
    .reset_n(reset_n),
    .set_i(seq_iteration_done_i),
    .clr_i((status_rd && sequence_finished_flag) || sequence_launch_wr_i || seq_wrap_i),
    .flag_o(sequence_finished_flag)
  );

  // Conversion completion; a new result beats the pre-result clear.
  asf_sticky u_conv (
    .clk(clk),
    .reset_n(reset_n),
    .set_i(result_wr_i),
    .clr_i((status_rd && conversion_finished_flag) || conversion_launch_wr_i || conv_pre_result_i),
    .flag_o(conversion_finished_flag)
  );

  // Assemble the live status word; unused bits 6 and 5 read as zero.
  always_comb
  begin
    status_now = '0;
    status_now[ASF_ABOVE_POS +: ASF_CHANNELS] = above_limit_flag;
    status_now[ASF_BELOW_POS +: ASF_CHANNELS] = below_limit_flag;
    status_now[ASF_GAIN_OVF_POS] = gain_cal_overflow_flag;
    status_now[ASF_UNREAD_POS] = unread_any;
    status_now[ASF_WAIT_POS] = wait_flag;
    status_now[ASF_CAL_POS] = cal_flag;
    status_now[ASF_SEQ_POS] = sequence_finished_flag;
    status_now[ASF_CONV_POS] = conversion_finished_flag;
  end

  // Mask next value, read data capture and interrupt level.
  always_comb
  begin
    irq_enable_mask_d = irq_enable_mask_q;
    if (mask_wr)
      irq_enable_mask_d = reg_wdata_i;
    rdata_d = rdata_q;
    if (status_rd)
      rdata_d = status_now;
    else if (reg_rd_i && (reg_addr_i == ASF_IRQ_ENABLE_OFFSET))
      rdata_d = irq_enable_mask_q;
    else if (reg_rd_i)
      rdata_d = '0;
    // Level follows the flags one cycle late, which keeps the pin glitch free.
    irq_n_d = !(|(status_now & irq_enable_mask_q));
  end

  // Register only.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_enable_mask_q <= ASF_IRQ_ENABLE_RESET;
      rdata_q <= ASF_FLAGS_RESET;
      irq_n_q <= 1'b1;
    end
    else
    begin
      irq_enable_mask_q <= irq_enable_mask_d;
      rdata_q <= rdata_d;
      irq_n_q <= irq_n_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign irq_out_n = irq_n_q;
endmodule
`default_nettype wire

// [rtl/asf_pkg.sv]
/*
  Package for the converter status flag bank: register offsets, field positions,
  reset values and the channel count.
  Assumes it is compiled before every design file that imports it.
*/
package asf_pkg;
  localparam int unsigned ASF_CHANNELS = 8;
  localparam int unsigned ASF_REG_W = 24;
  localparam logic [6:0] ASF_EVENT_FLAGS_OFFSET = 7'h38;
  localparam logic [6:0] ASF_IRQ_ENABLE_OFFSET = 7'h39;
  localparam logic [6:0] ASF_DATA_BASE_OFFSET = 7'h30;
  localparam int unsigned ASF_ABOVE_POS = 16;
  localparam int unsigned ASF_BELOW_POS = 8;
  localparam int unsigned ASF_GAIN_OVF_POS = 7;
  localparam int unsigned ASF_UNREAD_POS = 4;
  localparam int unsigned ASF_WAIT_POS = 3;
  localparam int unsigned ASF_CAL_POS = 2;
  localparam int unsigned ASF_SEQ_POS = 1;
  localparam int unsigned ASF_CONV_POS = 0;
  localparam logic [23:0] ASF_IRQ_ENABLE_RESET = 24'h000001;
  localparam logic [23:0] ASF_FLAGS_RESET = 24'h000000;
  localparam logic [23:0] ASF_GAIN_MAX_CODE = 24'hFFFFFF;
endpackage

// [rtl/asf_sticky.sv]
/*
  One sticky flag: set by an event, cleared by a request; the set wins.
  Assumes all inputs come from logic on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module asf_sticky (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);
  logic flag_q;
  logic flag_d;

  // A coincident event survives its own clear so nothing is lost.
  always_comb
  begin
    flag_d = flag_q;
    if (clr_i)
      flag_d = 1'b0;
    if (set_i)
      flag_d = 1'b1;
  end

  // Register only.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      flag_q <= 1'b0;
    else
      flag_q <= flag_d;
  end

  assign flag_o = flag_q;
endmodule
`default_nettype wire

// [rtl/asf_unread.sv]
/*
  Unread-result tracker: one bit per result register and their OR.
  Assumes write and read strobes are one-cycle pulses on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module asf_unread (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [asf_pkg::ASF_CHANNELS-1:0] written_i,
  input wire logic [asf_pkg::ASF_CHANNELS-1:0] read_i,
  output logic [asf_pkg::ASF_CHANNELS-1:0] bits_o,
  output logic any_o
);
  import asf_pkg::*;
  logic [ASF_CHANNELS-1:0] bits_q;
  logic [ASF_CHANNELS-1:0] bits_d;

  // New data beats a read landing in the same cycle, so fresh data stays unread.
  always_comb
  begin
    bits_d = (bits_q & ~read_i) | written_i;
  end

  // Register only.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      bits_q <= '0;
    else
      bits_q <= bits_d;
  end

  assign bits_o = bits_q;
  // The flag drops only once every pending register has been read.
  assign any_o = |bits_q;
endmodule
`default_nettype wire

// [tb/asf_status_flags_monitor.sv]
/* Checker for the status flag bank, bound to its top module.
   Assumes one clock and one-cycle register strobes. */
`timescale 1ns/1ps
`default_nettype none
module asf_status_flags_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [23:0] reg_wdata_i,
  input wire logic [23:0] reg_rdata_o,
  input wire logic result_wr_i,
  input wire logic wait_done_i,
  input wire logic wait_launch_wr_i,
  input wire logic conversion_launch_wr_i,
  input wire logic irq_out_n
);
  import asf_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [23:0] mask_q;
  wire logic rd38 = reg_rd_i && (reg_addr_i == ASF_EVENT_FLAGS_OFFSET);
  // Shadow of the enable mask, so the interrupt check only claims enabled flags.
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n) mask_q <= ASF_IRQ_ENABLE_RESET;
    else if (reg_wr_i && reg_addr_i == ASF_IRQ_ENABLE_OFFSET) mask_q <= reg_wdata_i;
  // Set wins over clear, so each clear check excludes a set in the cycles that count.
  sequence s_gap_rd(setv);
    !setv && !reg_rd_i ##1 rd38;
  endsequence
  property p_ev_clr(ev, setv, int b);
    ev && !setv ##1 s_gap_rd(setv) |=> !reg_rdata_o[b];
  endproperty
  property p_rd_clr(setv, int b);
    rd38 && !setv ##1 rd38 |=> !reg_rdata_o[b];
  endproperty
  chk_read_clr_conv: assert property (p_rd_clr(result_wr_i, 0))
    else $error("conv flag kept by read");
  chk_read_clr_wait: assert property (p_rd_clr(wait_done_i, 3))
    else $error("wait flag kept by read");
  chk_wait_start_clr: assert property (p_ev_clr(wait_launch_wr_i, wait_done_i, 3))
    else $error("wait flag kept by start");
  chk_conversion_launch_reg_clr: assert property (p_ev_clr(conversion_launch_wr_i, result_wr_i, 0))
    else $error("conv flag kept by start");
  chk_result_unread: assert property (result_wr_i ##1 !reg_rd_i ##1 rd38 |=> reg_rdata_o[4])
    else $error("unread flag missing");
  chk_read_keeps_unread: assert property (rd38 ##1 rd38 && reg_rdata_o[4] |=> reg_rdata_o[4])
    else $error("unread flag lost by read");
  chk_unused_zero: assert property (rd38 |=> reg_rdata_o[6:5] == 2'h0)
    else $error("unused bits set");
  chk_irq_conv: assert property (result_wr_i && mask_q[0] && !reg_wr_i |=> ##1 !irq_out_n)
    else $error("interrupt missing");
endmodule

bind asf_status_flags asf_status_flags_monitor i_mon (.clk(clk), .reset_n(reset_n), .reg_rd_i(reg_rd_i),
  .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .result_wr_i(result_wr_i), .wait_done_i(wait_done_i), .wait_launch_wr_i(wait_launch_wr_i),
  .conversion_launch_wr_i(conversion_launch_wr_i), .irq_out_n(irq_out_n));
`default_nettype wire

// [tb/asf_host.sv]
/* Host model: drives the register port with one-cycle strobes.
   Assumes it shares clk with the status flag bank. */
`timescale 1ns/1ps
`default_nettype none
module asf_host (
  input wire logic clk,
  input wire logic [23:0] reg_rdata_o,
  output var logic reg_rd_i,
  output var logic reg_wr_i,
  output var logic [6:0] reg_addr_i,
  output var logic [23:0] reg_wdata_i
);
  initial {reg_rd_i, reg_wr_i, reg_addr_i, reg_wdata_i} = '0;
  // One or two back-to-back reads; the address is inverted once released, never left stale.
  task automatic rd(input logic [6:0] a, input int n, output logic [23:0] d0, output logic [23:0] d1);
    @(posedge clk) reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk) reg_rd_i <= (n > 1);
    @(negedge clk) d0 = reg_rdata_o;
    if (n > 1) @(posedge clk) reg_rd_i <= 1'b0;
    @(negedge clk) d1 = reg_rdata_o;
    @(posedge clk) reg_addr_i <= ~a;
  endtask
  // A single write strobe.
  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    @(posedge clk) reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk) reg_wr_i <= 1'b0;
    reg_addr_i <= ~a;
    reg_wdata_i <= ~d;
  endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
/* Self-checking bench for the status flag bank.
   Assumes the host model owns the register port; the bench drives all events. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import asf_pkg::*;
  typedef struct {logic [10:0] e1; logic [10:0] e2; logic [2:0] s; logic [23:0] v; logic [1:0] x;
    logic [23:0] w;} asf_row_t;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [10:0] ev = 11'h000;
  logic [2:0] sel = 3'h0;
  logic [23:0] val = 24'h000000;
  logic [1:0] dx = 2'h0;
  logic rd, wr, irq_n;
  logic [6:0] addr;
  logic [23:0] wdata, rdata, d0, d1;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  // Event bits: result, gain cal, wait done, wait start, cal done, cal start, pass, sequence_launch_reg,
  // wraparound, conversion start, pre-result. Limits are 0x800000 and 0x100000.
  asf_row_t rows [15] = '{'{11'h001, 11'h000, 3'h0, 24'h900000, 2'h0, 24'h010011},
    '{11'h040, 11'h080, 3'h0, 24'h400000, 2'h0, 24'h000000},
    '{11'h001, 11'h000, 3'h7, 24'h800000, 2'h0, 24'h000011},
    '{11'h001, 11'h000, 3'h3, 24'h0FFFFF, 2'h0, 24'h000811},
    '{11'h001, 11'h000, 3'h5, 24'h400000, 2'h2, 24'h200011},
    '{11'h001, 11'h000, 3'h6, 24'h400000, 2'h1, 24'h004011},
    '{11'h004, 11'h000, 3'h0, 24'h400000, 2'h0, 24'h000008},
    '{11'h004, 11'h008, 3'h0, 24'h400000, 2'h0, 24'h000000},
    '{11'h010, 11'h000, 3'h0, 24'h400000, 2'h0, 24'h000004},
    '{11'h010, 11'h020, 3'h0, 24'h400000, 2'h0, 24'h000000},
    '{11'h040, 11'h000, 3'h0, 24'h400000, 2'h0, 24'h000002},
    '{11'h040, 11'h100, 3'h0, 24'h400000, 2'h0, 24'h000000},
    '{11'h001, 11'h200, 3'h0, 24'h400000, 2'h0, 24'h000010},
    '{11'h401, 11'h000, 3'h0, 24'h400000, 2'h0, 24'h000011},
    '{11'h002, 11'h000, 3'h0, 24'h123456, 2'h2, 24'h000084}};
  asf_status_flags i_asf_status_flags (.clk(clk), .reset_n(reset_n), .reg_rd_i(rd), .reg_wr_i(wr),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .result_wr_i(ev[0]), .result_sel_i(sel),
    .result_value_i(val), .digital_over_i(dx[1]), .digital_under_i(dx[0]), .upper_limit_setting(24'h800000),
    .lower_limit_setting(24'h100000), .gain_cal_done_i(ev[1]), .system_gain_coefficient(val),
    .gain_cal_saturated_i(dx[1]), .wait_done_i(ev[2]), .wait_launch_wr_i(ev[3]), .cal_done_i(ev[4]),
    .cal_launch_wr_i(ev[5]), .seq_iteration_done_i(ev[6]), .sequence_launch_wr_i(ev[7]), .seq_wrap_i(ev[8]),
    .conversion_launch_wr_i(ev[9]), .conv_pre_result_i(ev[10]), .irq_out_n(irq_n));
  asf_host i_asf_host (.clk(clk), .reg_rdata_o(rdata), .reg_rd_i(rd), .reg_wr_i(wr), .reg_addr_i(addr),
    .reg_wdata_i(wdata));
  always #2 clk = ~clk;
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Event pulses last one cycle, as the flag bank expects.
  task automatic pulse(input logic [10:0] m);
    @(posedge clk) ev <= m;
    @(posedge clk) ev <= 11'h000;
  endtask
  task automatic close_out();
    if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // A hang counts as a mismatch.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt++;
      close_out();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    foreach (rows[i])
    begin
      @(posedge clk) sel <= rows[i].s;
      val <= rows[i].v;
      dx <= rows[i].x;
      pulse(rows[i].e1);
      if (rows[i].e2 !== 11'h000) pulse(rows[i].e2);
      i_asf_host.rd(ASF_EVENT_FLAGS_OFFSET, 2, d0, d1);
      chk("status", rows[i].w, d0);
      chk("reread", rows[i].w & 24'h000010, d1);
      if (rows[i].w[4]) i_asf_host.rd(ASF_DATA_BASE_OFFSET + 7'(rows[i].s), 1, d0, d1);
    end
    // Two pending results: the unread flag waits for both data reads.
    @(posedge clk) sel <= 3'h2;
    val <= 24'h400000;
    dx <= 2'h0;
    pulse(11'h001);
    @(posedge clk) sel <= 3'h4;
    pulse(11'h001);
    i_asf_host.rd(7'h32, 1, d0, d1);
    i_asf_host.rd(ASF_EVENT_FLAGS_OFFSET, 1, d0, d1);
    chk("one pending", 24'h000011, d0);
    i_asf_host.rd(7'h34, 1, d0, d1);
    i_asf_host.rd(ASF_EVENT_FLAGS_OFFSET, 1, d0, d1);
    chk("none pending", 24'h000000, d0);
    // An overflowing gain calibration followed by a valid one leaves only the calibration flag.
    @(posedge clk) dx <= 2'h2;
    pulse(11'h002);
    dx <= 2'h0;
    pulse(11'h002);
    i_asf_host.rd(ASF_EVENT_FLAGS_OFFSET, 1, d0, d1);
    chk("gain valid", 24'h000004, d0);
    // Mask only the wait flag, then probe refused writes and an unmapped read.
    i_asf_host.wr(ASF_IRQ_ENABLE_OFFSET, 24'h000008);
    i_asf_host.wr(7'h3A, 24'hFFFFFF);
    i_asf_host.rd(ASF_IRQ_ENABLE_OFFSET, 1, d0, d1);
    chk("mask", 24'h000008, d0);
    i_asf_host.rd(7'h3A, 1, d0, d1);
    chk("unmapped", 24'h000000, d0);
    pulse(11'h001);
    repeat (2) @(negedge clk);
    chk("irq masked", 24'h000001, {23'h0, irq_n});
    pulse(11'h004);
    repeat (2) @(negedge clk);
    chk("irq on", 24'h000000, {23'h0, irq_n});
    i_asf_host.wr(ASF_EVENT_FLAGS_OFFSET, 24'h000000);
    i_asf_host.rd(ASF_EVENT_FLAGS_OFFSET, 1, d0, d1);
    chk("read only", 24'h000019, d0);
    // A second reset with the unread flag still pending.
    @(posedge clk) reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk("irq reset", 24'h000001, {23'h0, irq_n});
    reset_n <= 1'b1;
    i_asf_host.rd(ASF_IRQ_ENABLE_OFFSET, 1, d0, d1);
    chk("mask reset", 24'h000001, d0);
    i_asf_host.rd(ASF_EVENT_FLAGS_OFFSET, 1, d0, d1);
    chk("flags reset", 24'h000000, d0);
    close_out();
  end
endmodule
`default_nettype wire
